// ### rtl/eecc_pkg.sv
// package: register map, field layout and timing for the eeprom command control block
package eecc_pkg;

  localparam logic [11:0] EEPROM_COMMAND_CTRL_OFF = 12'h1B4;
  localparam logic [11:0] EEPROM_DATA_PORT_OFF    = 12'h1B8;
  localparam logic [11:0] IRQ_STATUS_OFF          = 12'h1C0;
  localparam logic [11:0] IRQ_MASK_OFF            = 12'h1C4;
  localparam logic [11:0] ADDR_SETTING_OFF        = 12'h1C8;

  localparam int BUSY_BIT = 31;
  localparam int OP_HI    = 30;
  localparam int OP_LO    = 28;

  localparam logic [31:0] CMD_RESET  = 32'h80000000;
  localparam logic [2:0]  OP_READ    = 3'h0;
  localparam logic [2:0]  OP_WRITE   = 3'h3;

  // status bits: 0 done, 1 timeout, 2 loader finished
  localparam int ST_DONE    = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_LOADED  = 2;
  localparam int ST_W       = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timeout for an absent eeprom, applied to write commands only; reads wait without limit
  localparam int TIMEOUT_US     = 30;
  localparam int CLK_MHZ        = 100;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    EECC_LOAD    = 3'b000,
    EECC_IDLE    = 3'b001,
    EECC_RD_WAIT = 3'b010,
    EECC_WR_WAIT = 3'b011
  } eecc_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } eecc_ee_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } eecc_ee_rsp_t;

endpackage

// ### rtl/eecc_ctrl.sv
// eeprom command control: axi4-lite registers, command sequencing and busy flag
`timescale 1ns/10ps
`default_nettype none

module eecc_ctrl #(
  parameter int TIMEOUT_CYCLES = eecc_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // eeprom bus engine and loader
  output eecc_pkg::eecc_ee_req_t     ee_req,
  input  wire eecc_pkg::eecc_ee_rsp_t ee_rsp,
  input  wire logic                  loader_done,
  // interrupt
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]           cmd_r;
  logic [31:0]           data_r;
  logic [15:0]           addr_r;
  logic [eecc_pkg::ST_W-1:0] stat_r;
  logic [eecc_pkg::ST_W-1:0] mask_r;
  eecc_pkg::eecc_state_t state_r;
  logic [31:0]           tmo_r;
  logic                  aw_got_r;
  logic                  w_got_r;
  logic [11:0]           awaddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  wr_go;
  logic                  start;
  logic                  finish;
  logic                  timeout;
  logic [eecc_pkg::ST_W-1:0] ev;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_got_r && w_got_r;

  // start only from idle; a busy write while busy is ignored by hardware
  assign start = wr_go && awaddr_r == eecc_pkg::EEPROM_COMMAND_CTRL_OFF && wstrb_r[3]
                 && wdata_r[eecc_pkg::BUSY_BIT] && state_r == eecc_pkg::EECC_IDLE;
  assign timeout = state_r == eecc_pkg::EECC_WR_WAIT
                   && tmo_r == 32'(TIMEOUT_CYCLES - 1);
  assign finish = ((state_r == eecc_pkg::EECC_RD_WAIT || state_r == eecc_pkg::EECC_WR_WAIT)
                  && ee_rsp.ack) || timeout
                  || (state_r == eecc_pkg::EECC_IDLE && cmd_r[eecc_pkg::BUSY_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // bus write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= eecc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_r)
          eecc_pkg::EEPROM_COMMAND_CTRL_OFF, eecc_pkg::EEPROM_DATA_PORT_OFF,
          eecc_pkg::IRQ_STATUS_OFF, eecc_pkg::IRQ_MASK_OFF,
          eecc_pkg::ADDR_SETTING_OFF: s_axi_bresp <= eecc_pkg::RESP_OKAY;
          default:                    s_axi_bresp <= eecc_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command register: busy self-clears, op code writable only when idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd_r <= eecc_pkg::CMD_RESET;
    else
    begin
      if (wr_go && awaddr_r == eecc_pkg::EEPROM_COMMAND_CTRL_OFF && wstrb_r[3]
          && state_r == eecc_pkg::EECC_IDLE)
        cmd_r[eecc_pkg::OP_HI:eecc_pkg::OP_LO] <= wdata_r[eecc_pkg::OP_HI:eecc_pkg::OP_LO];
      if (start)
        cmd_r[eecc_pkg::BUSY_BIT] <= 1'b1;
      else if (finish || (state_r == eecc_pkg::EECC_LOAD && loader_done))
        cmd_r[eecc_pkg::BUSY_BIT] <= 1'b0;
    end
  end

  // data port and address setting; read data lands as busy drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_r <= 32'h00000000;
      addr_r <= 16'h0000;
    end
    else
    begin
      if (state_r == eecc_pkg::EECC_RD_WAIT && ee_rsp.ack)
        data_r <= ee_rsp.rdata;
      else if (wr_go && awaddr_r == eecc_pkg::EEPROM_DATA_PORT_OFF)
        data_r <= wdata_r;
      if (wr_go && awaddr_r == eecc_pkg::ADDR_SETTING_OFF)
        addr_r <= wdata_r[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= eecc_pkg::EECC_LOAD;
      tmo_r   <= 32'h00000000;
    end
    else
    begin
      unique case (state_r)
        eecc_pkg::EECC_LOAD:
          if (loader_done)
            state_r <= eecc_pkg::EECC_IDLE;
        eecc_pkg::EECC_IDLE:
        begin
          tmo_r <= 32'h00000000;
          if (start)
          begin
            // reserved codes complete at once with no eeprom action
            unique case (wdata_r[eecc_pkg::OP_HI:eecc_pkg::OP_LO])
              eecc_pkg::OP_READ:  state_r <= eecc_pkg::EECC_RD_WAIT;
              eecc_pkg::OP_WRITE: state_r <= eecc_pkg::EECC_WR_WAIT;
              default:            state_r <= eecc_pkg::EECC_IDLE;
            endcase
          end
        end
        eecc_pkg::EECC_RD_WAIT:
          if (ee_rsp.ack)
            state_r <= eecc_pkg::EECC_IDLE;
        eecc_pkg::EECC_WR_WAIT:
        begin
          tmo_r <= tmo_r + 32'h00000001;
          if (finish)
            state_r <= eecc_pkg::EECC_IDLE;
        end
        default: state_r <= eecc_pkg::EECC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ee_req <= '0;
    else
    begin
      ee_req.req   <= state_r == eecc_pkg::EECC_RD_WAIT || state_r == eecc_pkg::EECC_WR_WAIT;
      ee_req.we    <= state_r == eecc_pkg::EECC_WR_WAIT;
      ee_req.addr  <= addr_r;
      ee_req.wdata <= data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set beats write-one-to-clear
  assign ev[eecc_pkg::ST_DONE]    = finish;
  assign ev[eecc_pkg::ST_TIMEOUT] = timeout;
  assign ev[eecc_pkg::ST_LOADED]  = state_r == eecc_pkg::EECC_LOAD && loader_done;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_r <= '0;
      mask_r <= '0;
    end
    else
    begin
      if (wr_go && awaddr_r == eecc_pkg::IRQ_STATUS_OFF)
        stat_r <= (stat_r & ~wdata_r[eecc_pkg::ST_W-1:0]) | ev;
      else
        stat_r <= stat_r | ev;
      if (wr_go && awaddr_r == eecc_pkg::IRQ_MASK_OFF)
        mask_r <= wdata_r[eecc_pkg::ST_W-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= eecc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= eecc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        eecc_pkg::EEPROM_COMMAND_CTRL_OFF: s_axi_rdata <= cmd_r;
        eecc_pkg::EEPROM_DATA_PORT_OFF:    s_axi_rdata <= data_r;
        eecc_pkg::IRQ_STATUS_OFF:          s_axi_rdata <= {29'h0, stat_r};
        eecc_pkg::IRQ_MASK_OFF:            s_axi_rdata <= {29'h0, mask_r};
        eecc_pkg::ADDR_SETTING_OFF:        s_axi_rdata <= {16'h0000, addr_r};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= eecc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  busy_after_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> cmd_r[eecc_pkg::BUSY_BIT]) else $error("busy not set after start");
  busy_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == eecc_pkg::EECC_RD_WAIT || state_r == eecc_pkg::EECC_WR_WAIT)
    |-> cmd_r[eecc_pkg::BUSY_BIT]) else $error("busy dropped mid operation");
  read_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == eecc_pkg::EECC_RD_WAIT && ee_rsp.ack)
    |=> !cmd_r[eecc_pkg::BUSY_BIT] && data_r == $past(ee_rsp.rdata))
    else $error("read data not valid at busy clear");
  timeout_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout |=> !cmd_r[eecc_pkg::BUSY_BIT] && stat_r[eecc_pkg::ST_TIMEOUT])
    else $error("busy not cleared on timeout");
  load_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == eecc_pkg::EECC_LOAD |-> cmd_r[eecc_pkg::BUSY_BIT])
    else $error("busy clear before loader done");
  op_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r != eecc_pkg::EECC_IDLE |=> $stable(cmd_r[eecc_pkg::OP_HI:eecc_pkg::OP_LO]))
    else $error("op code changed while busy");
  reserved_op_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (start && wdata_r[eecc_pkg::OP_HI:eecc_pkg::OP_LO] != eecc_pkg::OP_READ
     && wdata_r[eecc_pkg::OP_HI:eecc_pkg::OP_LO] != eecc_pkg::OP_WRITE)
    |=> state_r == eecc_pkg::EECC_IDLE ##1 !ee_req.req)
    else $error("reserved op touched eeprom");
  status_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    finish |=> stat_r[eecc_pkg::ST_DONE]) else $error("done status not set");

endmodule

`default_nettype wire

// ### verif/eecc_ee_model.sv
// serial eeprom partner model answering the command engine after a set delay
`timescale 1ns/10ps
`default_nettype none
module eecc_ee_model (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // engine side
  input  wire eecc_pkg::eecc_ee_req_t ee_req,
  output eecc_pkg::eecc_ee_rsp_t      ee_rsp,
  // test control
  input  wire logic                   present,
  input  wire logic [3:0]             delay
);
  logic [31:0] mem_r [0:15];
  logic [3:0]  wait_r;
  logic        done_r;
  // an absent part never answers; the data lines wander so stale data cannot pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ee_rsp <= '0;
      wait_r <= 4'h0;
      done_r <= 1'b0;
    end
    else
    begin
      ee_rsp.ack   <= 1'b0;
      ee_rsp.rdata <= ~ee_rsp.rdata;
      // one answer per request; the request lingers a cycle after the answer
      if (!ee_req.req)
      begin
        wait_r <= 4'h0;
        done_r <= 1'b0;
      end
      else if (present && !done_r)
      begin
        if (wait_r == delay)
        begin
          done_r     <= 1'b1;
          ee_rsp.ack <= 1'b1;
          if (ee_req.we)
            mem_r[ee_req.addr[3:0]] <= ee_req.wdata;
          else
            ee_rsp.rdata <= mem_r[ee_req.addr[3:0]];
        end
        else
          wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// testbench for the eeprom command control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int          TO   = 20;
  localparam logic [11:0] CMD  = eecc_pkg::EEPROM_COMMAND_CTRL_OFF;
  localparam logic [11:0] DAT  = eecc_pkg::EEPROM_DATA_PORT_OFF;
  localparam logic [11:0] STA  = eecc_pkg::IRQ_STATUS_OFF;
  localparam logic [11:0] MSK  = eecc_pkg::IRQ_MASK_OFF;
  localparam logic [11:0] ADR  = eecc_pkg::ADDR_SETTING_OFF;
  logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr, irq, ldone, present;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdd, rdat;
  logic [1:0]  bresp, rresp, resp, rrsp;
  logic [3:0]  delay;
  eecc_pkg::eecc_ee_req_t ee_req, seen;
  eecc_pkg::eecc_ee_rsp_t ee_rsp;
  int n_fail, cmp_count, cyc, req_cyc, t0, n0;

  eecc_ctrl #(.TIMEOUT_CYCLES(TO)) eecc_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .ee_req(ee_req), .ee_rsp(ee_rsp), .loader_done(ldone), .irq(irq));
  eecc_ee_model eecc_ee_model_i (.aclk(aclk), .aresetn(aresetn), .ee_req(ee_req),
    .ee_rsp(ee_rsp), .present(present), .delay(delay));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (ee_req.req)
    begin
      req_cyc++;
      seen <= ee_req;
    end
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    awv <= 1'b1;
    wd  <= d;
    wv  <= 1'b1;
    br  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
    end while (bv !== 1'b1);
    br   <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr   <= 1'b0;
    rdat = rdd;
    rrsp = rresp;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, rdat);
  endtask
  // host polls busy and issues nothing new until it drops
  task automatic idle();
    do rd(CMD); while (rdat[31] !== 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, awv, wv, br, arv, rr, ldone, awa, ara, wd} = '0;
    {n_fail, cmp_count, cyc, req_cyc} = '0;
    present = 1'b1;
    delay   = 4'h1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CMD, 32'h80000000, "busy after reset");
    repeat (6) @(posedge aclk);
    rc(CMD, 32'h80000000, "busy before load");
    ldone <= 1'b1;
    @(posedge aclk);
    ldone <= 1'b0;
    rc(CMD, 32'h00000000, "command after load");
    rc(STA, 32'h00000004, "loader status");
    wr(STA, 32'h00000007);
    wr(MSK, 32'h00000007);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test reset done");
    wr(DAT, 32'hA5A51234);
    wr(ADR, 32'h00000005);
    wr(CMD, 32'hB0000000);
    rc(CMD, 32'hB0000000, "busy during write");
    idle();
    rc(CMD, 32'h30000000, "op code kept");
    chk("write request we", 32'h1, {31'h0, seen.we});
    chk("write request addr", 32'h5, {16'h0, seen.addr});
    chk("write request data", 32'hA5A51234, seen.wdata);
    chk("irq done", 32'h1, {31'h0, irq});
    wr(STA, 32'h00000001);
    chk("irq after clear", 32'h0, {31'h0, irq});
    $display("test write done");
    delay <= 4'hC;
    wr(DAT, 32'h00000000);
    wr(CMD, 32'h80000000);
    idle();
    rc(DAT, 32'hA5A51234, "read data");
    chk("read request", 32'h0, {31'h0, seen.we});
    $display("test read done");
    for (int i = 0; i < 3; i++)
    begin
      n0 = req_cyc;
      wr(CMD, {1'b1, (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h4, 28'h0});
      idle();
      chk("reserved code request", n0, req_cyc);
    end
    $display("test reserved done");
    present <= 1'b0;
    wr(STA, 32'h00000007);
    t0 = cyc;
    wr(CMD, 32'hB0000000);
    idle();
    chk("busy held to timeout", 32'h1, {31'h0, (cyc - t0) >= TO});
    rd(STA);
    chk("timeout status", 32'h2, rdat & 32'h2);
    present <= 1'b1;
    wr(MSK, 32'h00000000);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MSK, 32'h00000002);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(STA, 32'h00000007);
    chk("irq after timeout clear", 32'h0, {31'h0, irq});
    rc(12'h100, 32'h0, "unmapped read data");
    chk("unmapped read resp", {30'h0, eecc_pkg::RESP_SLVERR}, {30'h0, rrsp});
    wr(12'h104, 32'h12345678);
    chk("unmapped write resp", {30'h0, eecc_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("test timeout and irq done");
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rc(CMD, 32'h80000000, "busy after second reset");
    rc(STA, 32'h00000000, "status after second reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
